// ==== rtl/wake_pkg.sv ====
/*
 wake_pkg: constants shared by the wake-on-lan detector.
 assumes a nibble-wide mii received stream and a 25 MHz core clock.
*/
package wake_pkg;
   localparam int          NUM_PATTERNS   = 4;               // user wake frames per port
   localparam int          ADDR_BYTES     = 6;               // station address length
   localparam int          ADDR_COPIES    = 16;              // address repeats in the pattern
   localparam int          SYNC_BYTES     = 6;               // all-ones bytes before the copies
   localparam logic [7:0]  SYNC_VALUE     = 8'hff;           // sync byte value
   localparam logic [31:0] CRC_INIT       = 32'hffff_ffff;   // crc preset
   localparam logic [31:0] CRC_POLY_REFL  = 32'hedb8_8320;   // reflected 802.3 polynomial
   localparam logic [31:0] CRC_RESIDUE    = 32'hdebb_20e3;   // good-frame residue
   localparam logic [3:0]  NIBBLE_RESET   = 4'h0;            // mii nibble reset value
endpackage

// ==== rtl/wake_on_lan_detector.sv ====
/*
 wake_on_lan_detector: receive-side wake detection for one ethernet port.
 assumes mii receive pins (rx clock, dv, er, data) from an external phy, sampled here on core_clk
 after two flip-flops; the rx clock is far slower than core_clk, so edges are found by sampling.
 the frame stream is assumed to start right after the sfd nibble pair.
*/
// Overview of operation
// - wake on link change, user wake frame match, or remote-wake pattern frame.
// - four independent user wake frame patterns per port, each can wake.
// - user wake frame matches when frame crc equals that pattern's configured crc.
// - while pattern detection enabled, scan every frame addressed to this node.
// - pattern frame valid only with own, multicast or broadcast destination and good crc.
// - pattern is sixteen back-to-back copies of the six-byte station address.
// - sixteen copies must directly follow six bytes of all ones.
// - sync run and copies may start at any byte offset.
// - broadcast frame accepted if its copies equal the local station address.
// - nothing else about frame contents affects detection.
// - frame without sequence is dropped and produces no wake; here a user wake frame match still wakes.
// - detected wake sequence signals power management to wake the system.
// - link up and link down transitions both report a wake event.
`timescale 1ns/100ps
module wake_on_lan_detector (
   input  wire logic        core_clk,        // 25 MHz core clock
   input  wire logic        rst,             // synchronous reset, active high
   input  wire logic        mii_rx_clk,      // phy receive clock, sampled
   input  wire logic        mii_rx_dv,       // receive data valid
   input  wire logic        mii_rx_er,       // receive error
   input  wire logic [3:0]  mii_rxd,         // receive nibble
   input  wire logic        link_up,         // link status from the phy
   input  wire logic [47:0] station_addr,    // own address, first byte in [47:40]
   input  wire logic        pattern_en,      // remote-wake pattern detection enable
   input  wire logic [3:0]  frame_en,        // per-pattern wake frame enable
   input  wire logic [31:0] frame_crc0,      // expected crc, pattern 0
   input  wire logic [31:0] frame_crc1,      // expected crc, pattern 1
   input  wire logic [31:0] frame_crc2,      // expected crc, pattern 2
   input  wire logic [31:0] frame_crc3,      // expected crc, pattern 3
   output logic             wake_q,          // one-cycle wake pulse to power management
   output logic             wake_link_q,     // one-cycle pulse: link change cause
   output logic [3:0]       wake_frame_q,    // one-cycle pulse per matching wake frame
   output logic             wake_pattern_q   // one-cycle pulse: pattern frame cause
);
   typedef enum logic [1:0] {
      ST_SYNC = 2'b01,
      ST_ADDR = 2'b10
   } scan_e;

   // crc-32 over one byte, lsb first as on the wire
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ b[i]) ? ((r >> 1) ^ wake_pkg::CRC_POLY_REFL) : (r >> 1);
      end
      return r;
   endfunction

   // synchronisers: first stage only feeds second stage
   logic [6:0] sync1_q, sync2_q;
   logic       clk_prev_q;
   always_ff @(posedge core_clk) begin
      sync1_q    <= {mii_rx_clk, mii_rx_dv, mii_rx_er, mii_rxd};
      sync2_q    <= sync1_q;
      clk_prev_q <= sync2_q[6];
   end
   wire       rx_edge = sync2_q[6] & ~clk_prev_q;
   wire       rx_dv   = sync2_q[5];
   wire       rx_er   = sync2_q[4];
   wire [3:0] rx_nib  = sync2_q[3:0];

   // link synchroniser and change detect
   logic link1_q, link2_q, link3_q;
   always_ff @(posedge core_clk) begin
      link1_q <= link_up;
      link2_q <= link1_q;
      link3_q <= rst ? 1'b0 : link2_q;
   end
   logic link_seen_q;
   always_ff @(posedge core_clk) begin
      if (rst) link_seen_q <= 1'b0;
      else     link_seen_q <= 1'b1;
   end
   // either direction counts; the first sample after reset is not an event
   wire link_change = link_seen_q & (link2_q ^ link3_q);

   // nibble pairing into bytes, low nibble first
   logic       half_q, in_frame_q, err_q;
   logic [3:0] low_q;
   logic [7:0] byte_q;
   logic       byte_vld_q;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         half_q     <= 1'b0;
         low_q      <= wake_pkg::NIBBLE_RESET;
         byte_q     <= 8'h00;
         byte_vld_q <= 1'b0;
         in_frame_q <= 1'b0;
         err_q      <= 1'b0;
      end else begin
         byte_vld_q <= 1'b0;
         if (rx_edge) begin
            in_frame_q <= rx_dv;
            if (rx_dv) begin
               err_q  <= (in_frame_q ? err_q : 1'b0) | rx_er;
               half_q <= in_frame_q ? ~half_q : 1'b1;
               if (!in_frame_q || !half_q) low_q <= rx_nib;
               else begin
                  byte_q     <= {rx_nib, low_q};
                  byte_vld_q <= 1'b1;
               end
            end
         end
      end
   end
   wire frame_end = rx_edge & in_frame_q & ~rx_dv;
   wire frame_start = rx_edge & ~in_frame_q & rx_dv;

   // running crc and destination check over first six bytes
   logic [31:0] crc_q;
   logic [3:0]  pos_q;
   logic        da_own_q, da_bc_q, da_mc_q;
   wire  [7:0]  own_byte = station_addr[47 - 8*pos_q[2:0] -: 8];
   always_ff @(posedge core_clk) begin
      if (rst || frame_start) begin
         crc_q    <= wake_pkg::CRC_INIT;
         pos_q    <= 4'h0;
         da_own_q <= 1'b1;
         da_bc_q  <= 1'b1;
         da_mc_q  <= 1'b0;
      end else if (byte_vld_q) begin
         crc_q <= crc_byte(crc_q, byte_q);
         if (pos_q < 4'(wake_pkg::ADDR_BYTES)) begin
            pos_q    <= pos_q + 4'h1;
            da_own_q <= da_own_q & (byte_q == own_byte);
            da_bc_q  <= da_bc_q & (byte_q == 8'hff);
            if (pos_q == 4'h0) da_mc_q <= byte_q[0];
         end
      end
   end
   // destination: own, multicast (broadcast included), or broadcast
   wire addr_ok = da_own_q | da_mc_q | da_bc_q;
   wire crc_ok  = (crc_q == wake_pkg::CRC_RESIDUE) & ~err_q;
   // complement of the running crc; not compared, only tied off through unused_ok
   wire [31:0] frame_crc = ~crc_q;
   wire [31:0] exp_crc [wake_pkg::NUM_PATTERNS];
   assign exp_crc[0] = frame_crc0;
   assign exp_crc[1] = frame_crc1;
   assign exp_crc[2] = frame_crc2;
   assign exp_crc[3] = frame_crc3;
   logic [31:0] crc_d1_q, crc_d2_q, crc_d3_q, crc_d4_q;
   // keep crc from four bytes back so it covers the frame minus its fcs
   always_ff @(posedge core_clk) begin
      if (rst || frame_start) begin
         crc_d1_q <= wake_pkg::CRC_INIT;
         crc_d2_q <= wake_pkg::CRC_INIT;
         crc_d3_q <= wake_pkg::CRC_INIT;
         crc_d4_q <= wake_pkg::CRC_INIT;
      end else if (byte_vld_q) begin
         crc_d1_q <= crc_q;
         crc_d2_q <= crc_d1_q;
         crc_d3_q <= crc_d2_q;
         crc_d4_q <= crc_d3_q;
      end
   end
   // after the last byte, crc_d4_q holds the crc of all bytes but the four fcs bytes
   wire [31:0] body_crc = ~crc_d4_q;
   logic [3:0] frame_hit;
   always_comb begin
      for (int p = 0; p < wake_pkg::NUM_PATTERNS; p++) begin
         frame_hit[p] = frame_en[p] & crc_ok & (body_crc == exp_crc[p]);
      end
   end

   // pattern scanner: sync run then address copies, any offset
   scan_e      st_q;
   logic [2:0] cnt_q;     // sync bytes or byte within copy
   logic [4:0] copy_q;    // copies completed
   logic       found_q;
   wire  [7:0] scan_exp = station_addr[47 - 8*cnt_q -: 8];
   wire        is_sync  = (byte_q == wake_pkg::SYNC_VALUE);
   wire        last_byte = (cnt_q == 3'(wake_pkg::ADDR_BYTES - 1));
   always_ff @(posedge core_clk) begin
      if (rst || frame_start) begin
         st_q    <= ST_SYNC;
         cnt_q   <= 3'h0;
         copy_q  <= 5'h00;
         found_q <= 1'b0;
      end else if (byte_vld_q && !found_q) begin
         case (st_q)
            ST_SYNC: begin
               // the sixth one in a row moves to ST_ADDR; longer runs are absorbed there
               if (is_sync) begin
                  if (cnt_q == 3'(wake_pkg::SYNC_BYTES - 1)) begin
                     st_q   <= ST_ADDR;
                     cnt_q  <= 3'h0;
                     copy_q <= 5'h00;
                  end else cnt_q <= cnt_q + 3'h1;
               end else cnt_q <= 3'h0;
            end
            ST_ADDR: begin
               if (byte_q == scan_exp) begin
                  cnt_q <= last_byte ? 3'h0 : cnt_q + 3'h1;
                  if (last_byte) begin
                     copy_q <= copy_q + 5'h01;
                     if (copy_q == 5'(wake_pkg::ADDR_COPIES - 1)) found_q <= 1'b1;
                  end
               end else if (copy_q == 5'h00 && cnt_q == 3'h0 && is_sync) begin
                  cnt_q <= 3'h0; // extra ones after the sync run: stay ready
               end else begin
                  // restart search from this byte
                  st_q  <= ST_SYNC;
                  cnt_q <= is_sync ? 3'h1 : 3'h0;
               end
            end
            default: begin
               st_q  <= ST_SYNC;
               cnt_q <= 3'h0;
            end
         endcase
      end
   end
   // no other content check: only sequence, address and crc matter
   wire pattern_hit = pattern_en & found_q & addr_ok & crc_ok;

   // outputs: one-cycle pulses at end of frame or link change
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wake_q         <= 1'b0;
         wake_link_q    <= 1'b0;
         wake_frame_q   <= 4'h0;
         wake_pattern_q <= 1'b0;
      end else begin
         wake_link_q    <= link_change;
         wake_frame_q   <= frame_end ? frame_hit : 4'h0;
         wake_pattern_q <= frame_end & pattern_hit;
         wake_q         <= link_change | (frame_end & (pattern_hit | (|frame_hit)));
      end
   end

   a_wake_cause: assert property (@(posedge core_clk) disable iff (rst)
      wake_q |-> (wake_link_q | wake_pattern_q | (|wake_frame_q))) else $error("wake without cause");
   a_pattern_wakes: assert property (@(posedge core_clk) disable iff (rst)
      wake_pattern_q |-> wake_q) else $error("pattern not waking");
   a_link_event: assert property (@(posedge core_clk) disable iff (rst)
      link_seen_q && $changed(link2_q) |=> wake_link_q && wake_q) else $error("link change lost");
   a_pattern_en: assert property (@(posedge core_clk) disable iff (rst)
      !$past(pattern_en) |-> !wake_pattern_q) else $error("pattern wake while disabled");
   a_pattern_crc: assert property (@(posedge core_clk) disable iff (rst)
      wake_pattern_q |-> $past(crc_ok) && $past(addr_ok)) else $error("invalid frame woke");
   a_no_seq: assert property (@(posedge core_clk) disable iff (rst)
      !$past(found_q) |-> !wake_pattern_q) else $error("wake without sequence");
   a_frame_en: assert property (@(posedge core_clk) disable iff (rst)
      (wake_frame_q & ~$past(frame_en)) == 4'h0) else $error("disabled frame woke");
   a_frame_crc: assert property (@(posedge core_clk) disable iff (rst)
      wake_frame_q[0] |-> $past(body_crc) == $past(frame_crc0)) else $error("crc mismatch woke");
   a_sync_done: assert property (@(posedge core_clk) disable iff (rst)
      $rose(st_q == ST_ADDR) |-> $past(is_sync) && $past(cnt_q) == 3'h5) else $error("short sync");
   a_pulse_once: assert property (@(posedge core_clk) disable iff (rst)
      wake_pattern_q |=> !wake_pattern_q) else $error("pattern pulse too long");

   c_pattern: cover property (@(posedge core_clk) wake_pattern_q);
   c_frame: cover property (@(posedge core_clk) |wake_frame_q);
   c_link_up: cover property (@(posedge core_clk) wake_link_q && link3_q);
   c_restart: cover property (@(posedge core_clk) st_q == ST_ADDR ##1 st_q == ST_SYNC);
   wire unused_ok = &{1'b0, frame_crc};
endmodule

// ==== test/phy_model.sv ====
/*
 phy_model: behavioural mii receive side of an external 10/100 phy.
 assumes the bench calls send from its own thread; rx clock stands still between frames.
*/
`timescale 1ns/100ps
module phy_model (
   output logic       rx_clk,   // receive clock, 320 ns period in frames
   output logic       rx_dv,    // data valid
   output logic       rx_er,    // receive error, raised on one chosen nibble
   output logic [3:0] rxd       // receive nibble
);
   initial begin
      rx_clk = 1'b0;
      rx_dv  = 1'b0;
      rx_er  = 1'b0;
      rxd    = 4'h0;
   end

   // low nibble first; idle data is inverted each cycle so stale nibbles never look valid
   // er_nib picks the nibble that carries rx_er; a negative value sends a clean frame
   task automatic send(input logic [7:0] q[$], input int er_nib = -1);
      logic [3:0] n;
      #13;
      for (int i = 0; i < 2 * q.size(); i++) begin
         n = i[0] ? q[i/2][7:4] : q[i/2][3:0];
         rx_dv = 1'b1;
         rx_er = (i == er_nib);
         rxd   = n;
         #160 rx_clk = 1'b1;
         #160 rx_clk = 1'b0;
      end
      for (int i = 0; i < 3; i++) begin
         rx_dv = 1'b0;
         rx_er = 1'b0;
         rxd   = ~rxd;
         #160 rx_clk = 1'b1;
         #160 rx_clk = 1'b0;
      end
   endtask
endmodule

// ==== test/tb_wake_on_lan_detector.sv ====
/*
 tb_wake_on_lan_detector: self-checking bench for the wake detector.
 assumes phy_model drives the mii pins; expected crcs are computed here.
*/
`timescale 1ns/100ps
module tb_wake_on_lan_detector;
   typedef logic [7:0] bq_t[$];
   typedef struct {logic [1:0] da; logic [1:0] brk; int slot; logic pen; logic [3:0] fen; logic ep; logic [3:0] ef;} row_s;
   localparam logic [47:0] SA = 48'h0a1b_2c3d_4e5f;
   logic        core_clk, rst, rx_clk, rx_dv, rx_er, link_up, pattern_en;
   logic [3:0]  rxd, frame_en, wake_frame_q, seen_f;
   logic [31:0] crc_cfg [4];
   logic        wake_q, wake_link_q, wake_pattern_q, seen_p, seen_l, clr_seen;
   int          wake_n, fail_count, tests_run;
   row_s        rows [13] = '{'{0,0,-1,1,15,1,0}, '{1,0,-1,1,15,1,0}, '{2,0,-1,1,15,1,0}, '{3,0,-1,1,15,0,0},
      '{0,1,-1,1,15,0,0}, '{0,2,-1,1,15,0,0}, '{0,3,-1,1,15,1,0}, '{0,0,-1,0,15,0,0}, '{0,0,0,1,15,0,1},
      '{0,0,1,1,15,0,2}, '{0,0,2,1,15,0,4}, '{0,0,3,1,15,0,8}, '{0,0,2,1,11,0,0}};

   phy_model i_phy (.rx_clk(rx_clk), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd));
   wake_on_lan_detector i_dut (.core_clk(core_clk), .rst(rst), .mii_rx_clk(rx_clk), .mii_rx_dv(rx_dv),
      .mii_rx_er(rx_er), .mii_rxd(rxd), .link_up(link_up), .station_addr(SA), .pattern_en(pattern_en),
      .frame_en(frame_en), .frame_crc0(crc_cfg[0]), .frame_crc1(crc_cfg[1]), .frame_crc2(crc_cfg[2]),
      .frame_crc3(crc_cfg[3]), .wake_q(wake_q), .wake_link_q(wake_link_q), .wake_frame_q(wake_frame_q),
      .wake_pattern_q(wake_pattern_q));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // sticky record of pulses, cleared by the main thread between cases
   always @(posedge core_clk) begin
      if (rst || clr_seen) begin
         seen_p <= 1'b0;
         seen_f <= 4'h0;
         seen_l <= 1'b0;
         wake_n <= 0;
      end else begin
         seen_p <= seen_p | wake_pattern_q;
         seen_f <= seen_f | wake_frame_q;
         seen_l <= seen_l | wake_link_q;
         if (wake_q === 1'b1) wake_n <= wake_n + 1;
      end
   end

   function automatic logic [31:0] fcs_of(input bq_t q);
      logic [31:0] c;
      c = wake_pkg::CRC_INIT;
      foreach (q[i]) begin
         c ^= {24'h0000_00, q[i]};
         for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ wake_pkg::CRC_POLY_REFL : c >> 1;
      end
      return ~c;
   endfunction

   // magic frames start with a broken sync run to exercise the restart path
   function automatic bq_t make_frame(input logic [1:0] da, input logic [1:0] brk, input int slot);
      bq_t         q;
      logic [47:0] d;
      logic [31:0] f;
      d = (da == 0) ? SA : (da == 1) ? 48'hffff_ffff_ffff : (da == 2) ? 48'h0100_5e00_0001 : 48'h0200_0000_0009;
      for (int i = 0; i < 6; i++) q.push_back(d[47-8*i -: 8]);
      for (int i = 0; i < 8; i++) q.push_back(i[7:0] + 8'h30);
      if (slot >= 0) for (int i = 0; i < 10; i++) q.push_back(slot[7:0]);
      else begin
         q = {q, 8'hff, 8'hff, 8'hff, 8'h00, 8'h5a};
         if (brk == 3) begin
            for (int i = 0; i < 6; i++) q.push_back(8'hff);
            q = {q, SA[47:40], SA[39:32], 8'h00};
         end
         for (int i = 0; i < 6; i++) q.push_back(wake_pkg::SYNC_VALUE);
         for (int c = 0; c < 96; c++) q.push_back(SA[47-8*(c%6) -: 8] ^ ((brk == 2 && c == 47) ? 8'h01 : 8'h00));
      end
      f = fcs_of(q);
      for (int i = 0; i < 4; i++) q.push_back(f[8*i +: 8] ^ ((brk == 1 && i == 3) ? 8'h01 : 8'h00));
      return q;
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // one-cycle clear request, so the sticky record keeps a single driver
   task automatic clear_seen();
      @(posedge core_clk) #2;
      clr_seen = 1'b1;
      @(posedge core_clk) #2;
      clr_seen = 1'b0;
   endtask

   initial begin
      #3_000_000;
      fail_count++;
      stop_test();
   end

   initial begin
      bq_t fq;
      rst = 1'b1;
      clr_seen = 1'b0;
      link_up = 1'b0;
      pattern_en = 1'b1;
      frame_en = 4'hf;
      fail_count = 0;
      tests_run = 0;
      // configured crc covers the wake frame body, without its fcs
      for (int k = 0; k < 4; k++) begin
         fq = make_frame(0, 0, k);
         crc_cfg[k] = fcs_of(fq[0:23]);
      end
      repeat (12) @(posedge core_clk);
      #2;
      check({4'h0, wake_q, wake_link_q, wake_pattern_q, 1'b0}, 8'h00);
      check({4'h0, wake_frame_q}, 8'h00);
      rst = 1'b0;
      repeat (6) @(posedge core_clk);
      foreach (rows[r]) begin
         clear_seen();
         pattern_en = rows[r].pen;
         frame_en = rows[r].fen;
         i_phy.send(make_frame(rows[r].da, rows[r].brk, rows[r].slot), -1);
         repeat (12) @(posedge core_clk);
         #2;
         check({3'h0, seen_p, seen_f}, {3'h0, rows[r].ep, rows[r].ef});
         check(wake_n[7:0], 8'(rows[r].ep + $countones(rows[r].ef)));
      end
      // an rx error inside an otherwise good pattern frame must not wake
      clear_seen();
      pattern_en = 1'b1;
      frame_en = 4'hf;
      i_phy.send(make_frame(0, 0, -1), 40);
      repeat (12) @(posedge core_clk);
      #2;
      check({3'h0, seen_p, seen_f}, 8'h00);
      check(wake_n[7:0], 8'h00);
      // both link directions must wake
      for (int t = 0; t < 2; t++) begin
         clear_seen();
         link_up = ~link_up;
         for (int i = 0; i < 20 && seen_l !== 1'b1; i++) @(posedge core_clk);
         repeat (3) @(posedge core_clk);
         #2;
         check({7'h00, seen_l}, 8'h01);
         check(wake_n[7:0], 8'h01);
      end
      // reset in mid-run with the link rising under it: no false link event after release
      rst = 1'b1;
      link_up = 1'b1;
      repeat (12) @(posedge core_clk);
      #2;
      check({4'h0, wake_q, wake_link_q, wake_pattern_q, 1'b0}, 8'h00);
      rst = 1'b0;
      repeat (10) @(posedge core_clk);
      #2;
      check({7'h00, seen_l}, 8'h00);
      check(wake_n[7:0], 8'h00);
      stop_test();
   end
endmodule
